// *** verilog/vcarb_regs.svh ***
// Notes on behaviour
// - Any table write sets the dirty flag.
// - Dirty stays set until a load completes with no table write during its copy.
// - Downstream ports always read dirty as zero.
// - Dirty matters only for table-using schemes.
// - Pending bit shows flow control init progress.
// - Slot is 4-bit port; 0,2,4 valid.
// - Invalid slots are skipped with no delay.
// - Eight nibbles per word at 0x220, 0x224.
// - Slots are read/write and reset to zero.
// - Status is read-only, reserved bits zero.
// - Writing one loads table; upstream only, reads zero.
// - Scheme select picks arbitration; table-using schemes only.
`ifndef VCARB_REGS_SVH
`define VCARB_REGS_SVH

`define VCARB_AW 12
`define VCARB_DW 32
`define VCARB_CTRL_OFS 12'h214
`define VCARB_STS_OFS 12'h218
`define VCARB_TBL0_OFS 12'h220
`define VCARB_TBL1_OFS 12'h224
`define VCARB_ISTS_OFS 12'h230
`define VCARB_IMSK_OFS 12'h234

`define VCARB_LOAD_BIT 16
`define VCARB_SCHEME_LSB 17
`define VCARB_SCHEME_MSB 19
`define VCARB_DIRTY_BIT 16
`define VCARB_NEG_BIT 17

`define VCARB_SLOTS 16
`define VCARB_SLOTS_PER_WORD 8
`define VCARB_LAST_SLOT 4'hF
`define VCARB_PORT0 4'h0
`define VCARB_PORT2 4'h2
`define VCARB_PORT4 4'h4
`define VCARB_SCHEME_TABLE_MASK 8'h3C

`define VCARB_EV_LOAD 0
`define VCARB_EV_FC 1
`define VCARB_NEV 2
`define VCARB_WORD_ZERO 32'h0000_0000

`endif

// *** verilog/vcarb_pkg.sv ***
package vcarb_pkg;
`include "vcarb_regs.svh"

    typedef logic [3:0] vcarb_port_t;
    typedef vcarb_port_t [`VCARB_SLOTS-1:0] vcarb_table_t;

    // Loader states, one-hot.
    typedef enum logic [1:0]
    {
        VCARB_LD_IDLE = 2'h1,
        VCARB_LD_COPY = 2'h2
    } vcarb_ld_state_t;

    // Grant seen by the egress scheduler.
    typedef struct packed
    {
        logic valid;
        vcarb_port_t slot;
        vcarb_port_t port;
    } vcarb_grant_t;

    // Slot stepper state.
    typedef struct packed
    {
        vcarb_port_t ptr;
    } vcarb_step_t;

    // Whole state of the top module.
    typedef struct packed
    {
        vcarb_table_t shadow;
        vcarb_table_t active;
        logic [2:0] scheme;
        logic dirty;
        logic rewrite;
        vcarb_ld_state_t ld_state;
        vcarb_port_t ld_idx;
        logic fc_pend;
        logic [`VCARB_NEV-1:0] ists;
        logic [`VCARB_NEV-1:0] imask;
        logic [`VCARB_DW-1:0] rdata;
        logic irq;
        vcarb_grant_t grant;
    } vcarb_state_t;

    // A slot counts only if it names a real port other than the egress itself.
    function automatic logic vcarb_slot_ok(vcarb_port_t p, vcarb_port_t egress);
        logic known;
        known = (p == `VCARB_PORT0) || (p == `VCARB_PORT2) || (p == `VCARB_PORT4);
        return known && (p != egress);
    endfunction

    // True for schemes that draw their service order from the table.
    function automatic logic vcarb_uses_table(logic [2:0] scheme);
        logic [7:0] mask;
        mask = `VCARB_SCHEME_TABLE_MASK;
        return mask[scheme];
    endfunction

endpackage

// *** verilog/vcarb_slot_step.sv ***
`timescale 1ns/100ps
module vcarb_slot_step
(
    input wire logic clk,
    input wire logic rst_n,
    input wire vcarb_pkg::vcarb_table_t slots,
    input wire vcarb_pkg::vcarb_port_t egress_id,
    input wire logic advance,
    input wire logic restart,
    output vcarb_pkg::vcarb_grant_t grant
);
    import vcarb_pkg::*;

    vcarb_step_t st_q;
    vcarb_step_t st_d;
    vcarb_port_t cur;
    vcarb_port_t idx;
    logic found;

    // Search from the pointer for the first usable slot in the same cycle,
    // so a bad slot costs no arbitration period at all.
    always_comb
    begin
        found = 1'b0;
        cur = st_q.ptr;
        idx = st_q.ptr;
        for (int i = 0; i < `VCARB_SLOTS; i++)
        begin
            idx = st_q.ptr + 4'(i);
            if (!found && vcarb_slot_ok(slots[idx], egress_id))
            begin
                found = 1'b1;
                cur = idx;
            end
        end
        grant.valid = found;
        grant.slot = cur;
        grant.port = slots[cur];
        st_d = st_q;
        if (restart)
            st_d.ptr = '0;
        else if (advance && found)
            st_d.ptr = cur + 4'h1;
    end

    // The pointer is four bits wide, so slot fifteen wraps to zero by itself.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_skip_invalid: assert property (grant.valid |-> vcarb_slot_ok(grant.port, egress_id))
        else $error("granted slot names an unusable port");

    a_step_order: assert property (advance && grant.valid && !restart |=> st_q.ptr == $past(cur) + 4'h1)
        else $error("pointer did not step past the served slot");

endmodule

// *** verilog/vcarb_top.sv ***
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "vcarb_regs.svh"
module vcarb_top
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [`VCARB_AW-1:0] ADDR,
    input wire logic [`VCARB_DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [`VCARB_DW-1:0] RDATA,
    output logic IRQ,
    input wire logic IS_UPSTREAM,
    input wire vcarb_pkg::vcarb_port_t EGRESS_ID,
    input wire logic FC_INIT_DONE,
    input wire logic ARB_ADVANCE,
    output vcarb_pkg::vcarb_grant_t GRANT
);
    import vcarb_pkg::*;

    localparam vcarb_state_t ST_RST = '{ld_state: VCARB_LD_IDLE, default: '0};

    logic [1:0] rst_sync_q;
    logic rst_n;
    vcarb_state_t st_q;
    vcarb_state_t st_d;
    vcarb_grant_t step_grant;
    logic tbl_wr;
    logic ld_go;
    logic ld_done;
    logic uses_table;
    logic [`VCARB_NEV-1:0] ev;
    logic [`VCARB_DW-1:0] rd_word;

    // Reset is applied at once but released through two flops so that no
    // flop leaves reset on a different edge than its neighbours.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            rst_sync_q <= '0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Decodes shared by the next-state logic and the checks.
    assign tbl_wr = WR && ((ADDR == `VCARB_TBL0_OFS) || (ADDR == `VCARB_TBL1_OFS));
    assign ld_go = WR && (ADDR == `VCARB_CTRL_OFS) && WDATA[`VCARB_LOAD_BIT]
        && IS_UPSTREAM && (st_q.ld_state == VCARB_LD_IDLE);
    assign ld_done = (st_q.ld_state == VCARB_LD_COPY) && (st_q.ld_idx == `VCARB_LAST_SLOT);
    assign uses_table = vcarb_uses_table(st_q.scheme);

    // The stepper only ever sees the loaded copy, never the shadow.
    vcarb_slot_step u_step
    (
        .clk(CLK),
        .rst_n(rst_n),
        .slots(st_q.active),
        .egress_id(EGRESS_ID),
        .advance(ARB_ADVANCE && uses_table),
        .restart(ld_done),
        .grant(step_grant)
    );

    // Read mux; unmapped addresses return zero.
    always_comb
    begin
        rd_word = `VCARB_WORD_ZERO;
        unique case (ADDR)
            `VCARB_CTRL_OFS:
            begin
                rd_word[`VCARB_SCHEME_MSB:`VCARB_SCHEME_LSB] = st_q.scheme;
            end
            `VCARB_STS_OFS:
            begin
                rd_word[`VCARB_DIRTY_BIT] = st_q.dirty && IS_UPSTREAM;
                rd_word[`VCARB_NEG_BIT] = st_q.fc_pend;
            end
            `VCARB_TBL0_OFS:
                rd_word = st_q.shadow[`VCARB_SLOTS_PER_WORD-1:0];
            `VCARB_TBL1_OFS:
                rd_word = st_q.shadow[`VCARB_SLOTS-1:`VCARB_SLOTS_PER_WORD];
            `VCARB_ISTS_OFS:
                rd_word[`VCARB_NEV-1:0] = st_q.ists;
            `VCARB_IMSK_OFS:
                rd_word[`VCARB_NEV-1:0] = st_q.imask;
            default:
                rd_word = `VCARB_WORD_ZERO;
        endcase
    end

    // Events that raise sticky interrupt bits.
    always_comb
    begin
        ev = '0;
        ev[`VCARB_EV_LOAD] = ld_done;
        ev[`VCARB_EV_FC] = st_q.fc_pend && FC_INIT_DONE;
    end

    // Next state of the whole block.
    always_comb
    begin
        st_d = st_q;
        st_d.rdata = RD ? rd_word : `VCARB_WORD_ZERO;
        st_d.fc_pend = !FC_INIT_DONE;

        // Software writes land in the shadow table and the control fields.
        if (WR && (ADDR == `VCARB_TBL0_OFS))
            st_d.shadow[`VCARB_SLOTS_PER_WORD-1:0] = WDATA;
        if (WR && (ADDR == `VCARB_TBL1_OFS))
            st_d.shadow[`VCARB_SLOTS-1:`VCARB_SLOTS_PER_WORD] = WDATA;
        if (WR && (ADDR == `VCARB_CTRL_OFS))
            st_d.scheme = WDATA[`VCARB_SCHEME_MSB:`VCARB_SCHEME_LSB];
        if (WR && (ADDR == `VCARB_IMSK_OFS))
            st_d.imask = WDATA[`VCARB_NEV-1:0];

        // Loader copies one slot per cycle; a load request while copying is
        // ignored, which keeps the span of a load fixed at sixteen cycles.
        unique case (st_q.ld_state)
            VCARB_LD_IDLE:
            begin
                if (ld_go)
                begin
                    st_d.ld_state = VCARB_LD_COPY;
                    st_d.ld_idx = '0;
                end
            end
            VCARB_LD_COPY:
            begin
                st_d.active[st_q.ld_idx] = st_q.shadow[st_q.ld_idx];
                st_d.ld_idx = st_q.ld_idx + 4'h1;
                if (ld_done)
                    st_d.ld_state = VCARB_LD_IDLE;
            end
        endcase

        // A write during a copy may have missed the copy, so remember it and
        // keep the table marked incoherent after the copy ends.
        if (ld_go)
            st_d.rewrite = 1'b0;
        else if (st_q.ld_state == VCARB_LD_COPY)
            st_d.rewrite = st_q.rewrite || tbl_wr;

        // Set wins over the end-of-load clear.
        st_d.dirty = tbl_wr || (st_q.dirty && !(ld_done && !st_q.rewrite));
        if (st_q.dirty && ld_done && !st_q.rewrite && !tbl_wr)
            st_d.dirty = 1'b0;

        // Sticky interrupt bits: write one to clear, a new event wins.
        if (WR && (ADDR == `VCARB_ISTS_OFS))
            st_d.ists = st_q.ists & ~WDATA[`VCARB_NEV-1:0];
        st_d.ists = st_d.ists | ev;
        st_d.irq = |(st_d.ists & st_d.imask);

        // The grant is only offered when the scheme reads the table.
        st_d.grant.valid = step_grant.valid && uses_table;
        st_d.grant.slot = step_grant.slot;
        st_d.grant.port = step_grant.port;
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= ST_RST;
        else
            st_q <= st_d;
    end

    // Outputs come straight from state flops.
    assign RDATA = st_q.rdata;
    assign IRQ = st_q.irq;
    assign GRANT = st_q.grant;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sequence s_load_req;
        ld_go;
    endsequence

    sequence s_copy_half;
        (st_q.ld_state == VCARB_LD_COPY)[*8];
    endsequence

    sequence s_word0_written;
        WR && (ADDR == `VCARB_TBL0_OFS);
    endsequence

    sequence s_word0_read;
        RD && (ADDR == `VCARB_TBL0_OFS);
    endsequence

    a_dirty_on_write: assert property (tbl_wr |=> st_q.dirty)
        else $error("table write did not set the dirty flag");

    a_dirty_held: assert property (st_q.dirty && !ld_done |=> st_q.dirty)
        else $error("dirty flag dropped before the load finished");

    a_dirty_cleared: assert property (ld_done && !st_q.rewrite && !tbl_wr |=> !st_q.dirty)
        else $error("dirty flag not cleared after a clean load");

    a_load_span: assert property (s_load_req |=> s_copy_half ##1 s_copy_half
        ##1 (st_q.ld_state == VCARB_LD_IDLE))
        else $error("table load did not take sixteen cycles");

    a_down_dirty: assert property (!IS_UPSTREAM && RD && (ADDR == `VCARB_STS_OFS)
        ##1 !IS_UPSTREAM |-> !RDATA[`VCARB_DIRTY_BIT])
        else $error("downstream port reported a dirty table");

    a_neg_pending: assert property (RD && (ADDR == `VCARB_STS_OFS)
        |=> RDATA[`VCARB_NEG_BIT] == $past(st_q.fc_pend))
        else $error("pending bit does not follow flow control init");

    a_sts_reserved: assert property (RD && (ADDR == `VCARB_STS_OFS)
        |=> (RDATA[`VCARB_DIRTY_BIT-1:0] == '0) && (RDATA[`VCARB_DW-1:`VCARB_NEG_BIT+1] == '0))
        else $error("reserved status bits read nonzero");

    a_word0_back: assert property (s_word0_written ##1 s_word0_read
        |=> RDATA == $past(WDATA, 2))
        else $error("table word 0 did not read back as written");

    a_load_upstream: assert property (!IS_UPSTREAM && WR && (ADDR == `VCARB_CTRL_OFS)
        && (st_q.ld_state == VCARB_LD_IDLE) |=> st_q.ld_state == VCARB_LD_IDLE)
        else $error("downstream port started a table load");

    a_load_reads0: assert property (RD && (ADDR == `VCARB_CTRL_OFS) |=> !RDATA[`VCARB_LOAD_BIT])
        else $error("load request bit read as one");

    a_scheme_gate: assert property (!uses_table |=> !GRANT.valid)
        else $error("grant offered under a scheme that ignores the table");

    a_grant_port: assert property (GRANT.valid |-> vcarb_slot_ok(GRANT.port, $past(EGRESS_ID)))
        else $error("grant names an unusable port");

    // Only the loader may move the active table, one slot per copy cycle.
    a_copy_slot: assert property (st_q.ld_state == VCARB_LD_COPY |=>
        st_q.active[$past(st_q.ld_idx)] == $past(st_q.shadow[st_q.ld_idx]))
        else $error("active slot does not match the copied shadow slot");

    a_active_frozen: assert property (st_q.ld_state == VCARB_LD_IDLE && !ld_go |=>
        $stable(st_q.active))
        else $error("active table changed outside a load");

    a_ld_start: assert property (s_load_req |=> st_q.ld_idx == '0)
        else $error("table copy did not start at slot zero");

    // A write that races the copy must keep the table marked incoherent.
    a_rewrite_keeps: assert property (ld_done && st_q.rewrite |=> st_q.dirty)
        else $error("dirty flag cleared although the table changed during the copy");

    a_load_event: assert property (ld_done |=> st_q.ists[`VCARB_EV_LOAD])
        else $error("load completion did not raise its status bit");

    a_status_dirty_up: assert property (IS_UPSTREAM && RD && (ADDR == `VCARB_STS_OFS) |=>
        RDATA[`VCARB_DIRTY_BIT] == $past(st_q.dirty))
        else $error("upstream status read does not show the dirty flag");

    // The pending bit is one cycle behind the flow control input.
    a_neg_follows: assert property ($past(rst_n) |->
        st_q.fc_pend == !$past(FC_INIT_DONE))
        else $error("pending flag does not track flow control init");

    a_shadow_w0: assert property (WR && (ADDR == `VCARB_TBL0_OFS) |=>
        st_q.shadow[`VCARB_SLOTS_PER_WORD-1:0] == $past(WDATA))
        else $error("table word 0 write did not land in its slots");

    a_shadow_w1: assert property (WR && (ADDR == `VCARB_TBL1_OFS) |=>
        st_q.shadow[`VCARB_SLOTS-1:`VCARB_SLOTS_PER_WORD] == $past(WDATA))
        else $error("table word 1 write did not land in its slots");

    a_scheme_write: assert property (WR && (ADDR == `VCARB_CTRL_OFS) |=>
        st_q.scheme == $past(WDATA[`VCARB_SCHEME_MSB:`VCARB_SCHEME_LSB]))
        else $error("scheme select did not take the written value");

    a_grant_offered: assert property (uses_table && step_grant.valid |=> GRANT.valid)
        else $error("usable slot not offered under a table scheme");

endmodule

// *** tb/vcarb_egress_model.sv ***
`timescale 1ns/100ps
// Stands in for the egress scheduler that consumes grants, and for flow control init.
module vcarb_egress_model
#(
    parameter int FC_DELAY = 40
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire vcarb_pkg::vcarb_grant_t grant,
    output logic arb_advance,
    output logic fc_init_done
);
    import vcarb_pkg::*;
    int cnt;

    // A period is consumed only while one is granted, so a stray pulse never reaches the arbiter.
    // Flow control init finishes a fixed time after reset, late enough to be seen pending.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arb_advance <= 1'b0;
            fc_init_done <= 1'b0;
            cnt <= 0;
        end
        else
        begin
            arb_advance <= step && grant.valid;
            if (cnt < FC_DELAY)
                cnt <= cnt + 1;
            fc_init_done <= (cnt >= FC_DELAY);
        end
    end
endmodule

// *** tb/vcarb_tb_top.sv ***
`timescale 1ns/100ps
`include "vcarb_regs.svh"
module vcarb_tb_top;
    import vcarb_pkg::*;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic IS_UPSTREAM = 1'b1;
    logic step = 1'b0;
    logic [`VCARB_AW-1:0] ADDR = '0;
    logic [`VCARB_DW-1:0] WDATA = '0;
    logic [`VCARB_DW-1:0] RDATA;
    logic IRQ;
    logic FC_INIT_DONE;
    logic ARB_ADVANCE;
    vcarb_port_t EGRESS_ID = 4'h4;
    vcarb_grant_t GRANT;
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] lfsr = 32'h0001_4FCE;
    vcarb_table_t tbl;
    vcarb_port_t exp_slot;
    vcarb_port_t picks [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};

    vcarb_top i_vcarb_top (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .IS_UPSTREAM(IS_UPSTREAM), .EGRESS_ID(EGRESS_ID),
        .FC_INIT_DONE(FC_INIT_DONE), .ARB_ADVANCE(ARB_ADVANCE), .GRANT(GRANT));
    vcarb_egress_model i_vcarb_egress_model (.clk(CLK), .rst_n(RSTN), .step(step),
        .grant(GRANT), .arb_advance(ARB_ADVANCE), .fc_init_done(FC_INIT_DONE));

    // The clock toggles every half period of 2 ns.
    always #2 CLK = ~CLK;

    // Galois shift register, so every run draws the same values.
    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
    endfunction

    // Next slot from s upward that names a real port other than the egress.
    function automatic vcarb_port_t next_slot(vcarb_port_t s);
        vcarb_port_t idx;
        for (int i = 0; i < 16; i++)
        begin
            idx = s + 4'(i);
            if ((tbl[idx] == 4'h0 || tbl[idx] == 4'h2 || tbl[idx] == 4'h4) && tbl[idx] != EGRESS_ID)
                return idx;
        end
        return s;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        check(RDATA, exp, msg);
    endtask

    // Write a word and read it back on the very next strobe, with no idle cycle.
    task automatic wrrd(input logic [11:0] a, input logic [31:0] d, input string msg);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        check(RDATA, d, msg);
    endtask

    task automatic write_table();
        wr(`VCARB_TBL0_OFS, tbl[7:0]);
        wr(`VCARB_TBL1_OFS, tbl[15:8]);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // A hang is cut short here and counted as a mismatch.
    initial
    begin
        repeat (20000) @(posedge CLK);
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge CLK);
        rdc(`VCARB_STS_OFS, 32'h0002_0000, "status at reset");
        rdc(`VCARB_TBL0_OFS, 32'h0000_0000, "word0 at reset");
        rdc(`VCARB_TBL1_OFS, 32'h0000_0000, "word1 at reset");
        $display("test reset done");
        for (int r = 0; r < 4; r++)
        begin
            lfsr = lfsr_next(lfsr);
            tbl[7:0] = lfsr;
            lfsr = lfsr_next(lfsr);
            tbl[15:8] = lfsr;
            wr(`VCARB_TBL1_OFS, tbl[15:8]);
            wrrd(`VCARB_TBL0_OFS, tbl[7:0], "word0 readback");
            rdc(`VCARB_TBL1_OFS, tbl[15:8], "word1 readback");
        end
        repeat (60) @(posedge CLK);
        rdc(`VCARB_STS_OFS, 32'h0001_0000, "dirty after writes");
        rdc(`VCARB_ISTS_OFS, 32'h0000_0002, "fc done event");
        wr(`VCARB_STS_OFS, 32'hFFFF_FFFF);
        rdc(`VCARB_STS_OFS, 32'h0001_0000, "status write ignored");
        rdc(12'h2F0, 32'h0000_0000, "unmapped read");
        $display("test registers done");
        // Reserved ids and the egress id are placed on purpose to see them skipped.
        for (int i = 0; i < 16; i++)
        begin
            lfsr = lfsr_next(lfsr);
            tbl[i] = picks[lfsr[7:0] % 6];
        end
        tbl[0] = 4'h2;
        write_table();
        wr(`VCARB_IMSK_OFS, 32'h0000_0001);
        wr(`VCARB_ISTS_OFS, 32'h0000_0003);
        wr(`VCARB_CTRL_OFS, 32'h0005_0000);
        repeat (20) @(posedge CLK);
        rdc(`VCARB_STS_OFS, 32'h0000_0000, "dirty after load");
        rdc(`VCARB_CTRL_OFS, 32'h0004_0000, "load bit reads zero");
        check({31'h0, IRQ}, 32'h1, "irq on load done");
        rdc(`VCARB_ISTS_OFS, 32'h0000_0001, "load done event");
        wr(`VCARB_ISTS_OFS, 32'h0000_0001);
        repeat (2) @(posedge CLK);
        check({31'h0, IRQ}, 32'h0, "irq after clear");
        $display("test load done");
        exp_slot = next_slot(4'h0);
        check({23'h0, GRANT}, {23'h0, 1'b1, exp_slot, tbl[exp_slot]}, "first grant");
        for (int k = 0; k < 20; k++)
        begin
            step <= 1'b1;
            @(posedge CLK);
            step <= 1'b0;
            repeat (6) @(posedge CLK);
            exp_slot = next_slot(exp_slot + 4'h1);
            check({23'h0, GRANT}, {23'h0, 1'b1, exp_slot, tbl[exp_slot]}, "grant");
        end
        $display("test arbitration done");
        // A table write while the copy runs must leave the table marked incoherent.
        wr(`VCARB_CTRL_OFS, 32'h0005_0000);
        wr(`VCARB_TBL1_OFS, tbl[15:8]);
        repeat (20) @(posedge CLK);
        rdc(`VCARB_STS_OFS, 32'h0001_0000, "dirty kept after write in copy");
        $display("test rewrite done");
        for (int s = 0; s < 8; s++)
        begin
            wr(`VCARB_CTRL_OFS, 32'(s) << 17);
            repeat (4) @(posedge CLK);
            check({31'h0, GRANT.valid}, {31'h0, s >= 2 && s <= 5}, "scheme use");
        end
        $display("test schemes done");
        IS_UPSTREAM <= 1'b0;
        wr(`VCARB_TBL0_OFS, 32'h0000_0022);
        rdc(`VCARB_STS_OFS, 32'h0000_0000, "downstream dirty");
        wr(`VCARB_CTRL_OFS, 32'h0005_0000);
        repeat (20) @(posedge CLK);
        IS_UPSTREAM <= 1'b1;
        rdc(`VCARB_STS_OFS, 32'h0001_0000, "downstream load ignored");
        $display("test downstream done");
        wrap_up();
    end
endmodule
